// ### hw/sea_top.v
`timescale 1ns/1ps
`default_nettype none
`include "sea_regs.vh"
module sea_top #(
	parameter WORDS      = `SEA_WORDS,
	parameter WORD_W     = `SEA_WORD_W,
	parameter MIN_IVL_CYC = `SEA_MIN_IVL_CYC
) (
	input  wire CORE_CLK_I,
	input  wire NRST_I,
	input  wire SER_CLK_I,
	input  wire MODE_CODE_BIT_ONE_I,
	input  wire MODE_CODE_BIT_TWO_I,
	input  wire MODE_CODE_BIT_THREE_I,
	input  wire DATA_I,
	output reg  DATA_O,
	output reg  DATA_OE_O,
	output reg  BUSY_O
);
	localparam        AW       = `SEA_ADDR_W;
	localparam [31:0] IVL_MIN  = MIN_IVL_CYC;
	localparam [31:0] IVL_LAST = MIN_IVL_CYC - 1;
	localparam [31:0] IVL_TOP  = 32'hffffffff;

	// Mode code, bit one lowest
	wire [2:0]        mode = {MODE_CODE_BIT_THREE_I, MODE_CODE_BIT_TWO_I,
		MODE_CODE_BIT_ONE_I};

	reg               sclk_q;
	reg  [2:0]        mode_q;
	reg  [19:0]       addr_sh;
	reg  [AW-1:0]     addr;
	reg               addr_ok;
	reg  [WORD_W-1:0] shreg;
	reg  [31:0]       ivl_cnt;
	reg               mem_we;
	reg  [WORD_W-1:0] mem_wd;
	reg  [1:0]        rd_pend;

	reg  [19:0]       next_addr_sh;
	reg  [AW-1:0]     next_addr;
	reg               next_addr_ok;
	reg  [WORD_W-1:0] next_shreg;
	reg  [31:0]       next_ivl_cnt;
	reg               next_mem_we;
	reg  [WORD_W-1:0] next_mem_wd;
	reg  [1:0]        next_rd_pend;
	reg               next_data;
	reg               next_oe;
	reg               next_busy;
	wire [WORD_W-1:0] rdata;

	// Serial clock edges, seen at the first core clock edge that samples the new pin level
	wire              rise     = SER_CLK_I & ~sclk_q;
	wire              fall     = ~SER_CLK_I & sclk_q;
	wire              mode_new = (mode != mode_q);
	wire              held_min = ~mode_new & (ivl_cnt == IVL_LAST);

	// Decodes of the modes that drive the pin or the array
	wire              in_erase = (mode == `SEA_MODE_ERASE);
	wire              in_write = (mode == `SEA_MODE_WRITE);
	wire              in_shift = (mode == `SEA_MODE_SHIFT);
	wire              timed    = in_erase | in_write;

	// One-hot digit to binary; an invalid code sets the top bit
	function [4:0] dec10;
		input [9:0] oh;
		integer k;
		begin
			dec10 = 5'h10;
			for (k = 0; k < 10; k = k + 1)
				if (oh == (10'h001 << k))
					dec10 = k[4:0];
		end
	endfunction

	// Address as it stands once the bit now on the pin is taken
	wire [19:0]       addr_in  = {addr_sh[18:0], DATA_I};
	wire [4:0]        tens     = dec10(addr_in[19:10]);
	wire [4:0]        units    = dec10(addr_in[9:0]);
	wire [6:0]        tens_x8  = {tens[3:0], 3'h0};
	wire [6:0]        tens_x2  = {2'h0, tens[3:0], 1'h0};
	wire [6:0]        word_sel = tens_x8 + tens_x2 + {3'h0, units[3:0]};
	wire              code_ok  = ~tens[4] & ~units[4];

	sea_mem #(
		.DEPTH (WORDS),
		.AW    (AW),
		.DW    (WORD_W)
	) sea_mem_inst (
		.clk   (CORE_CLK_I),
		.we    (mem_we),
		.waddr (addr),
		.wdata (mem_wd),
		.raddr (addr),
		.rdata (rdata)
	);

	// Interval timer, busy flag and array commit
	always @*
	begin
		next_ivl_cnt = ivl_cnt;
		next_mem_we  = 1'h0;
		next_mem_wd  = mem_wd;
		// Restarts on every mode change and sticks at its top
		if (mode_new)
			next_ivl_cnt = `SEA_RST_CNT;
		else if (ivl_cnt != IVL_TOP)
			next_ivl_cnt = ivl_cnt + 32'h00000001;
		// Busy from the first sample of erase or write until the commit
		next_busy = timed && (mode_new || ivl_cnt < IVL_MIN);
		// A mode dropped before the minimum interval commits nothing
		if (timed && held_min && addr_ok)
		begin
			next_mem_we = 1'h1; // Only the addressed word
			if (in_erase)
				next_mem_wd = `SEA_ERASED_WORD;
			else
				next_mem_wd = shreg;
		end
	end

	// Serial side: address, data and shift-out
	always @*
	begin
		next_addr_sh = addr_sh;
		next_addr    = addr;
		next_addr_ok = addr_ok;
		next_shreg   = shreg;
		next_data    = DATA_O;
		next_rd_pend = {rd_pend[0], 1'h0};
		next_oe      = in_shift; // Pin driven only in shift-out
		case (mode)
		`SEA_MODE_ACCEPT:
			if (fall)
			begin
				next_addr_sh = addr_in;
				next_addr    = word_sel;
				next_addr_ok = code_ok;
			end
		`SEA_MODE_ACCDATA:
			if (fall)
				next_shreg = {shreg[WORD_W-2:0], DATA_I};
		`SEA_MODE_READ:
			if (mode_new)
				next_rd_pend = 2'h1;
		`SEA_MODE_SHIFT:
			if (rise)
			begin
				next_data  = shreg[WORD_W-1];
				next_shreg = {shreg[WORD_W-2:0], 1'h0};
			end
		default:
			;
		endcase
		// Array word reaches the shift register two cycles into a read
		if (rd_pend[1])
			next_shreg = addr_ok ? rdata : `SEA_ERASED_WORD;
	end

	// Pin sampling
	always @(posedge CORE_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			sclk_q <= 1'h0;
			mode_q <= `SEA_MODE_STANDBY;
		end
		else
		begin
			sclk_q <= SER_CLK_I;
			mode_q <= mode;
		end
	end

	// Serial registers and pin outputs
	always @(posedge CORE_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			addr_sh   <= `SEA_RST_CODE;
			addr      <= `SEA_RST_ADDR;
			addr_ok   <= 1'h0;
			shreg     <= `SEA_RST_WORD;
			rd_pend   <= 2'h0;
			DATA_O    <= 1'h0;
			DATA_OE_O <= 1'h0;
		end
		else
		begin
			addr_sh   <= next_addr_sh;
			addr      <= next_addr;
			addr_ok   <= next_addr_ok;
			shreg     <= next_shreg;
			rd_pend   <= next_rd_pend;
			DATA_O    <= next_data;
			DATA_OE_O <= next_oe;
		end
	end

	// Timer and array write port
	always @(posedge CORE_CLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			ivl_cnt <= `SEA_RST_CNT;
			mem_we  <= 1'h0;
			mem_wd  <= `SEA_RST_WORD;
			BUSY_O  <= 1'h0;
		end
		else
		begin
			ivl_cnt <= next_ivl_cnt;
			mem_we  <= next_mem_we;
			mem_wd  <= next_mem_wd;
			BUSY_O  <= next_busy;
		end
	end
endmodule
`default_nettype wire

// ### common/sea_regs.vh
`ifndef SEA_REGS_VH
`define SEA_REGS_VH
`define SEA_WORDS        100
`define SEA_WORD_W       14
`define SEA_ADDR_W       7
`define SEA_DIGITS       10
`define SEA_MODE_STANDBY 3'h0
`define SEA_MODE_READ    3'h1
`define SEA_MODE_ERASE   3'h2
`define SEA_MODE_ACCEPT  3'h3
`define SEA_MODE_WRITE   3'h4
`define SEA_MODE_SHIFT   3'h5
`define SEA_MODE_ACCDATA 3'h6
`define SEA_MODE_READOUT 3'h7
`define SEA_ERASED_WORD  14'h3fff
`define SEA_CLK_HZ       10000000
`define SEA_MIN_IVL_US   16000
`define SEA_MIN_IVL_CYC  ((`SEA_MIN_IVL_US * (`SEA_CLK_HZ / 1000000)))
`define SEA_RST_CODE     20'h00000
`define SEA_RST_ADDR     7'h00
`define SEA_RST_WORD     14'h0000
`define SEA_RST_CNT      32'h00000000
`endif

// ### hw/sea_mem.v
`timescale 1ns/1ps
`default_nettype none
module sea_mem #(
	parameter DEPTH = 100,
	parameter AW    = 7,
	parameter DW    = 14
) (
	input  wire          clk,
	input  wire          we,
	input  wire [AW-1:0] waddr,
	input  wire [DW-1:0] wdata,
	input  wire [AW-1:0] raddr,
	output reg  [DW-1:0] rdata
);
	reg [DW-1:0] mem [0:DEPTH-1];

	always @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// ### tb/sea_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sea_chk (
	input wire logic CORE_CLK_I,
	input wire logic NRST_I,
	input wire logic SER_CLK_I,
	input wire logic MODE_CODE_BIT_ONE_I,
	input wire logic MODE_CODE_BIT_TWO_I,
	input wire logic MODE_CODE_BIT_THREE_I,
	input wire logic DATA_I,
	input wire logic DATA_O,
	input wire logic DATA_OE_O,
	input wire logic BUSY_O
);
	wire [2:0] m = {MODE_CODE_BIT_THREE_I, MODE_CODE_BIT_TWO_I,
		MODE_CODE_BIT_ONE_I};
	wire       t = m == 3'h2 || m == 3'h4;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!NRST_I);
	oe_on_a: assert property (m == 3'h5 |=> DATA_OE_O)
		else $error("pin not driven in shift");
	oe_off_a: assert property (m != 3'h5 |=> !DATA_OE_O)
		else $error("pin driven outside shift");
	out_edge_a: assert property ($changed(DATA_O) && DATA_OE_O |->
		$past(SER_CLK_I) && !$past(SER_CLK_I, 2))
		else $error("data changed off rise");
	busy_src_a: assert property (BUSY_O |-> $past(t))
		else $error("busy outside timed mode");
	busy_on_a: assert property ($rose(t) ##1 t [*4] |-> BUSY_O)
		else $error("busy missing");
	idle_quiet_a: assert property (!m ##1 !m |-> !BUSY_O)
		else $error("busy in standby");
	cover property (m == 3'h5 && DATA_OE_O);
	cover property ($fell(BUSY_O) && t);
	cover property (m == 3'h6 && $fell(SER_CLK_I));
endmodule
bind sea_top sea_chk sea_chk_inst (
	.CORE_CLK_I            (CORE_CLK_I),
	.NRST_I                (NRST_I),
	.SER_CLK_I             (SER_CLK_I),
	.MODE_CODE_BIT_ONE_I   (MODE_CODE_BIT_ONE_I),
	.MODE_CODE_BIT_TWO_I   (MODE_CODE_BIT_TWO_I),
	.MODE_CODE_BIT_THREE_I (MODE_CODE_BIT_THREE_I),
	.DATA_I                (DATA_I),
	.DATA_O                (DATA_O),
	.DATA_OE_O             (DATA_OE_O),
	.BUSY_O                (BUSY_O)
);
`default_nettype wire

// ### tb/sea_host.sv
`timescale 1ns/1ps
`default_nettype none
module sea_host (
	input  wire logic       clk,
	input  wire logic       dout,
	input  wire logic       doe,
	output logic            sclk,
	output logic [2:0]      mode,
	output logic            din
);
	logic hd = 1'b0;
	logic hv = 1'b0;
	logic last = 1'b0;
	// Undriven line shows the inverse of its last level
	assign din = doe ? dout : (hd ? hv : ~last);
	always @(posedge clk)
		last <= din;
	initial
	begin
		sclk = 1'b0;
		mode = 3'h0;
	end
	// Bit set at the rise, held across the fall
	task tick(input logic b, output logic r);
		hv <= b;
		sclk <= 1'b1;
		repeat (4) @(posedge clk);
		r = din;
		sclk <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task op(input logic [2:0] md, input int n, input logic [19:0] v,
		input int hold, output logic [19:0] r);
		r = '0;
		mode <= md;
		hd <= md == 3'h3 || md == 3'h6;
		@(posedge clk);
		for (int i = n - 1; i >= 0; i--)
			tick(v[i], r[i]);
		repeat (hold) @(posedge clk);
		hd <= 1'b0;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// ### tb/test_sea_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_sea_top;
	logic       clk = 1'b0;
	logic       nrst = 1'b0;
	logic       sclk, din, dout, doe, busy;
	logic [2:0] mode;
	int         num_errors = 0;
	int         check_count = 0;
	localparam int IVL = 20;
	always #50 clk = ~clk;
	sea_top #(.MIN_IVL_CYC(IVL)) sea_top_inst (.CORE_CLK_I(clk),
		.NRST_I(nrst), .SER_CLK_I(sclk), .MODE_CODE_BIT_ONE_I(mode[0]),
		.MODE_CODE_BIT_TWO_I(mode[1]), .MODE_CODE_BIT_THREE_I(mode[2]),
		.DATA_I(din), .DATA_O(dout), .DATA_OE_O(doe), .BUSY_O(busy));
	sea_host sea_host_inst (.clk(clk), .dout(dout), .doe(doe),
		.sclk(sclk), .mode(mode), .din(din));
	function automatic logic [19:0] enc(int a);
		return {10'h1 << (a / 10), 10'h1 << (a % 10)};
	endfunction
	task finish_test;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Busy from the start of a timed mode until its minimum interval ends
	task chk_busy(int h);
		repeat (5) @(posedge clk);
		check_count++;
		if (busy !== 1'b1)
		begin
			num_errors++;
			$display("mismatch %0t got %h exp %h", $time, busy, 1'b1);
		end
		if (h >= IVL + 3)
		begin
			repeat (IVL) @(posedge clk);
			check_count++;
			if (busy !== 1'b0)
			begin
				num_errors++;
				$display("mismatch %0t got %h exp %h", $time, busy, 1'b0);
			end
		end
	endtask
	task wr(int a, logic [13:0] d, int h);
		logic [19:0] r;
		sea_host_inst.op(3'h3, 20, enc(a), 0, r);
		sea_host_inst.op(3'h6, 14, {6'h0, d}, 0, r);
		fork
			sea_host_inst.op(3'h2, 0, 20'h0, h, r);
			chk_busy(h);
		join
		sea_host_inst.op(3'h4, 0, 20'h0, h, r);
	endtask
	task rd(logic [19:0] c, logic [13:0] e);
		logic [19:0] r;
		sea_host_inst.op(3'h3, 20, c, 0, r);
		sea_host_inst.op(3'h1, 0, 20'h0, 6, r);
		sea_host_inst.op(3'h5, 14, 20'h0, 0, r);
		check_count++;
		if (r[13:0] !== e)
		begin
			num_errors++;
			$display("mismatch %0t got %h exp %h", $time, r[13:0], e);
		end
	endtask
	initial
	begin
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		wr(0, 14'h2a5a, 30);
		wr(99, 14'h1c3c, 30);
		rd(enc(0), 14'h2a5a);
		rd(enc(99), 14'h1c3c);
		wr(0, 14'h0f0f, 30);
		rd(enc(0), 14'h0f0f);
		rd(enc(99), 14'h1c3c);
		rd(20'h00c01, 14'h3fff);
		wr(99, 14'h0555, 10);
		rd(enc(99), 14'h1c3c);
		finish_test;
	end
endmodule
`default_nettype wire
